// >>> mio_signal_logic.sv
// Motion I/O signal logic with AXI4-Lite register slave
//
// Local design decisions: the address map and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "mio_defs.svh"

// Behaviour
// - Fault reset input rising edge clears latched internal or driver alarm.
// - Launch 0: start rise begins sequence, or resumes pause if running.
// - Launch 1: start rise begins sequence; start fall aborts it.
// - Sequence program is picked from general inputs one to seven.
// - Abort rise ends sequence and motion with decelerating stop.
// - Jog inputs start continuous motion plus or minus, no target.
// - Homing inputs start home seeking positive or negative.
// - Brake free on when local, remote free input or free command.
// - Free status active exactly while free is active.
// - Error clear copies feedback to command; clears driver counter if no alarm.
// - Torque-limit output follows torque-limit input.
// - Unassigned general outputs are plain ports set by command or sequence.
// - Signals default normally open; normally closed inverts on and off.
// - Alarm output changes on alarm; cause readable and blinked.
// - Alarm output restored by fault reset input or command.
// - Motion end follows pulse end, end area, or driver end.
// - Running while sequence runs; drops when final motion starts.
// - Moving while pulses issue; new motions rejected meanwhile.
// - Moving ignores driver moving input; used only in sensorless homing.
module mio_signal_logic
   import mio_pkg::*;
#(
   parameter int BLINK_CYC = `MIO_BLINK_MS * (`MIO_CLK_HZ / 1000)
)(
   input  wire logic                   core_clk,
   input  wire logic                   resetn,
   input  wire logic [`MIO_ADDR_W-1:0] awaddr,
   input  wire logic                   awvalid,
   output logic                        awready,
   input  wire logic [31:0]            wdata,
   input  wire logic [3:0]             wstrb,
   input  wire logic                   wvalid,
   output logic                        wready,
   output logic [1:0]                  bresp,
   output logic                        bvalid,
   input  wire logic                   bready,
   input  wire logic [`MIO_ADDR_W-1:0] araddr,
   input  wire logic                   arvalid,
   output logic                        arready,
   output logic [31:0]                 rdata,
   output logic [1:0]                  rresp,
   output logic                        rvalid,
   input  wire logic                   rready,
   input  wire mio_pins_t              pinsIn,
   input  wire logic                   remoteFreeIn,
   input  wire logic                   pulseBusy,
   input  wire logic                   inEndArea,
   input  wire logic                   driverEndIn,
   input  wire logic                   driverMoveIn,
   input  wire logic                   driverAlarmIn,
   input  wire logic                   protFaultIn,
   input  wire logic [7:0]             protCauseIn,
   input  wire logic                   seqLastMotionIn,
   input  wire logic                   seqDoneIn,
   input  wire logic                   seqOutWe,
   input  wire logic [3:0]             seqOutVal,
   input  wire logic [31:0]            feedbackPosition,
   input  wire logic [31:0]            commandedPosition,
   output logic                        seqStart,
   output logic                        seqResume,
   output logic                        seqAbort,
   output logic [6:0]                  seqProgram,
   output mio_motion_t                 motionReq,
   output logic                        motionStop,
   output logic                        cmdPosLoad,
   output logic [31:0]                 cmdPosValue,
   output logic                        devClear,
   output logic                        homePressSense,
   output logic                        ledOn,
   output mio_outs_t                   pinsOut
);
   localparam int PW = $bits(mio_pins_t);
   localparam int OW = $bits(mio_outs_t);

   function automatic logic [31:0] mergeStrb(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic isMapped(input logic [`MIO_ADDR_W-1:0] a);
      return (a[1:0] == 2'b00) && (a <= `MIO_ADDR_FAULT);
   endfunction

   logic [31:0]            ctrl_reg;
   logic [31:0]            inPol_reg;
   logic [31:0]            outPol_reg;
   logic [31:0]            gout_reg;
   logic [`MIO_ADDR_W-1:0] awAddr_reg;
   logic [31:0]            wData_reg;
   logic [3:0]             wStrb_reg;
   logic                   awHeld_reg;
   logic                   wHeld_reg;
   logic                   doWrite;
   logic                   cmdFreset;
   logic                   cmdAbort;
   logic                   cmdStart;
   logic [PW-1:0]          sync1_reg;
   logic [PW-1:0]          sync2_reg;
   logic [PW-1:0]          prevLog_reg;
   logic [PW-1:0]          logNow;
   logic [PW-1:0]          riseVec;
   logic [PW-1:0]          fallVec;
   mio_pins_t              lg;
   mio_pins_t              rise;
   mio_pins_t              fall;
   logic                   running_reg;
   logic                   homing_reg;
   logic                   prevBusy_reg;
   logic                   alarm_reg;
   logic [7:0]             cause_reg;
   logic                   drvAlmPrev_reg;
   logic                   alarmSet;
   logic                   alarmClr;
   logic                   freeStatus;
   logic                   motionEnd;
   logic                   abortAny;
   logic                   startRise;
   logic [31:0]            status;
   logic [31:0]            posErr;
   logic [31:0]            readMux;
   logic [OW-1:0]          outLogic;
   mio_outs_t              outFunc;
   mio_blink_t             blink_reg;
   logic [31:0]            tick_reg;
   logic                   tick;
   logic [3:0]             blinkCnt_reg;
   logic [2:0]             gapCnt_reg;

   // AXI4-Lite write channel
   assign awready = !awHeld_reg && !bvalid;
   assign wready  = !wHeld_reg && !bvalid;
   assign doWrite = awHeld_reg && wHeld_reg && !bvalid;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         awHeld_reg <= 1'b0;
         wHeld_reg  <= 1'b0;
         awAddr_reg <= '0;
         wData_reg  <= '0;
         wStrb_reg  <= '0;
         bvalid     <= 1'b0;
         bresp      <= `MIO_RESP_OK;
      end else begin
         if (awvalid && awready) begin
            awHeld_reg <= 1'b1;
            awAddr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            wHeld_reg <= 1'b1;
            wData_reg <= wdata;
            wStrb_reg <= wstrb;
         end
         if (doWrite) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            bvalid     <= 1'b1;
            bresp      <= isMapped(awAddr_reg) ? `MIO_RESP_OK : `MIO_RESP_ERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // Configuration registers; read-only offsets ignore writes
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_reg   <= `MIO_CTRL_RST;
         inPol_reg  <= `MIO_POL_RST;
         outPol_reg <= `MIO_POL_RST;
         gout_reg   <= `MIO_GOUT_RST;
      end else begin
         if (doWrite && awAddr_reg == `MIO_ADDR_CTRL) begin
            ctrl_reg <= mergeStrb(ctrl_reg, wData_reg, wStrb_reg);
         end
         if (doWrite && awAddr_reg == `MIO_ADDR_INPOL) begin
            inPol_reg <= mergeStrb(inPol_reg, wData_reg, wStrb_reg);
         end
         if (doWrite && awAddr_reg == `MIO_ADDR_OUTPOL) begin
            outPol_reg <= mergeStrb(outPol_reg, wData_reg, wStrb_reg);
         end
         if (seqOutWe) begin
            gout_reg[3:0] <= seqOutVal;
         end else if (doWrite && awAddr_reg == `MIO_ADDR_GOUT) begin
            gout_reg <= mergeStrb(gout_reg, wData_reg, wStrb_reg);
         end
      end
   end

   // Command strobes, one cycle each
   assign cmdFreset = doWrite && awAddr_reg == `MIO_ADDR_CMD && wStrb_reg[0]
                      && wData_reg[`MIO_CMD_FRESET];
   assign cmdAbort  = doWrite && awAddr_reg == `MIO_ADDR_CMD && wStrb_reg[0]
                      && wData_reg[`MIO_CMD_ABORT];
   assign cmdStart  = doWrite && awAddr_reg == `MIO_ADDR_CMD && wStrb_reg[0]
                      && wData_reg[`MIO_CMD_START];

   // AXI4-Lite read channel
   assign arready = !rvalid;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rvalid <= 1'b0;
         rdata  <= '0;
         rresp  <= `MIO_RESP_OK;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rdata  <= readMux;
         rresp  <= isMapped(araddr) ? `MIO_RESP_OK : `MIO_RESP_ERR;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   always_comb begin
      case (araddr)
         `MIO_ADDR_CTRL:   readMux = ctrl_reg;
         `MIO_ADDR_INPOL:  readMux = inPol_reg;
         `MIO_ADDR_OUTPOL: readMux = outPol_reg;
         `MIO_ADDR_GOUT:   readMux = gout_reg;
         `MIO_ADDR_STATUS: readMux = status;
         `MIO_ADDR_POSERR: readMux = posErr;
         `MIO_ADDR_FAULT:  readMux = {24'h00_0000, cause_reg};
         default:          readMux = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sync1_reg   <= '0;
         sync2_reg   <= '0;
         prevLog_reg <= '0;
      end else begin
         sync1_reg   <= pinsIn;
         sync2_reg   <= sync1_reg;
         prevLog_reg <= logNow;
      end
   end

   assign logNow  = sync2_reg ^ inPol_reg[PW-1:0];
   assign riseVec = logNow & ~prevLog_reg;
   assign fallVec = ~logNow & prevLog_reg;
   assign lg      = logNow;
   assign rise    = riseVec;
   assign fall    = fallVec;

   assign abortAny  = rise.abort || cmdAbort;
   assign startRise = rise.start || cmdStart;

   // Sequence launch; registered pulses
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         seqStart   <= 1'b0;
         seqResume  <= 1'b0;
         seqAbort   <= 1'b0;
         seqProgram <= '0;
         motionStop <= 1'b0;
      end else begin
         // resume when running in launch 0
         seqResume  <= startRise && running_reg && !abortAny
                       && !ctrl_reg[`MIO_CTRL_LAUNCH];
         seqStart   <= startRise && !running_reg && !abortAny;
         // falling start aborts in launch 1
         seqAbort   <= abortAny || (fall.start && running_reg
                       && ctrl_reg[`MIO_CTRL_LAUNCH]);
         motionStop <= abortAny;
         if (startRise && !running_reg) begin
            seqProgram <= lg.generalIn;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         running_reg <= 1'b0;
      end else if (startRise && !running_reg && !abortAny) begin
         running_reg <= 1'b1;
      end else if (seqLastMotionIn || seqDoneIn || abortAny
                   || (fall.start && ctrl_reg[`MIO_CTRL_LAUNCH])) begin
         running_reg <= 1'b0;
      end
   end

   // Motion requests; fixed priority among simultaneous edges
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         motionReq <= MIO_MV_NONE;
      end else begin
         motionReq <= MIO_MV_NONE;
         if (!pulseBusy && !abortAny) begin
            if (rise.jogPos) begin
               motionReq <= MIO_MV_JOG_POS;
            end else if (rise.jogNeg) begin
               motionReq <= MIO_MV_JOG_NEG;
            end else if (rise.homePos) begin
               motionReq <= MIO_MV_HOME_POS;
            end else if (rise.homeNeg) begin
               motionReq <= MIO_MV_HOME_NEG;
            end
         end
      end
   end

   // Homing window ends on busy fall or abort
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         homing_reg   <= 1'b0;
         prevBusy_reg <= 1'b0;
      end else begin
         prevBusy_reg <= pulseBusy;
         if (!pulseBusy && !abortAny && (rise.homePos || rise.homeNeg)
             && !rise.jogPos && !rise.jogNeg) begin
            homing_reg <= 1'b1;
         end else if ((prevBusy_reg && !pulseBusy) || abortAny) begin
            homing_reg <= 1'b0;
         end
      end
   end

   // driver moving only seen in sensorless homing
   assign homePressSense = ctrl_reg[`MIO_CTRL_SLESS] && homing_reg && driverMoveIn;

   // alarm latch; set wins over clear
   assign alarmSet = protFaultIn || (driverAlarmIn && !drvAlmPrev_reg);
   // clear by input edge or command
   assign alarmClr = rise.faultReset || cmdFreset;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         alarm_reg      <= 1'b0;
         cause_reg      <= '0;
         drvAlmPrev_reg <= 1'b0;
      end else begin
         drvAlmPrev_reg <= driverAlarmIn;
         if (alarmSet) begin
            alarm_reg <= 1'b1;
            cause_reg <= protFaultIn ? protCauseIn : `MIO_CAUSE_DRIVER;
         end else if (alarmClr) begin
            alarm_reg <= 1'b0;
            cause_reg <= '0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cmdPosLoad  <= 1'b0;
         cmdPosValue <= '0;
         devClear    <= 1'b0;
      end else begin
         cmdPosLoad <= rise.poserrClear;
         devClear   <= rise.poserrClear && !driverAlarmIn;
         if (rise.poserrClear) begin
            cmdPosValue <= feedbackPosition;
         end
      end
   end

   assign posErr = commandedPosition - feedbackPosition;

   // Blink divider; long period, so a parameter for simulation
   assign tick = (tick_reg == 32'(BLINK_CYC - 1));

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         tick_reg <= '0;
      end else if (!alarm_reg || tick) begin
         tick_reg <= '0;
      end else begin
         tick_reg <= tick_reg + 32'h0000_0001;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         blink_reg    <= MIO_BL_IDLE;
         blinkCnt_reg <= '0;
         gapCnt_reg   <= '0;
      end else if (!alarm_reg) begin
         blink_reg <= MIO_BL_IDLE;
      end else if (tick) begin
         case (blink_reg)
            MIO_BL_IDLE: begin
               blink_reg    <= MIO_BL_ON;
               blinkCnt_reg <= cause_reg[3:0];
            end
            MIO_BL_ON: begin
               blink_reg <= MIO_BL_OFF;
            end
            MIO_BL_OFF: begin
               if (blinkCnt_reg <= 4'h1) begin
                  blink_reg  <= MIO_BL_GAP;
                  gapCnt_reg <= `MIO_BLINK_GAP;
               end else begin
                  blink_reg    <= MIO_BL_ON;
                  blinkCnt_reg <= blinkCnt_reg - 4'h1;
               end
            end
            MIO_BL_GAP: begin
               if (gapCnt_reg <= 3'h1) begin
                  blink_reg <= MIO_BL_IDLE;
               end else begin
                  gapCnt_reg <= gapCnt_reg - 3'h1;
               end
            end
            default: blink_reg <= MIO_BL_IDLE;
         endcase
      end
   end

   assign ledOn = (blink_reg == MIO_BL_ON);

   assign freeStatus = lg.free || remoteFreeIn || ctrl_reg[`MIO_CTRL_FREE];

   always_comb begin
      if (ctrl_reg[`MIO_CTRL_DFIN]) begin
         motionEnd = driverEndIn;
      end else if (ctrl_reg[`MIO_CTRL_CRIT_MSB:`MIO_CTRL_CRIT_LSB] == 8'h00) begin
         motionEnd = !pulseBusy;
      end else begin
         motionEnd = !pulseBusy && inEndArea;
      end
   end

   always_comb begin
      outFunc.alarm       = alarm_reg;
      outFunc.motionEnd   = motionEnd;
      outFunc.running     = running_reg;
      outFunc.moving      = pulseBusy;
      outFunc.torqueLimit = lg.torqueLimit;
      outFunc.brakeFree   = freeStatus;
      outFunc.generalOut[0] = gout_reg[`MIO_GOUT_ASN_LSB] ? alarm_reg : gout_reg[0];
      outFunc.generalOut[1] = gout_reg[`MIO_GOUT_ASN_LSB+1] ? motionEnd : gout_reg[1];
      outFunc.generalOut[2] = gout_reg[`MIO_GOUT_ASN_LSB+2] ? running_reg : gout_reg[2];
      outFunc.generalOut[3] = gout_reg[`MIO_GOUT_ASN_MSB] ? pulseBusy : gout_reg[3];
   end

   assign outLogic = outFunc ^ outPol_reg[OW-1:0];
   assign pinsOut  = outLogic;

   always_comb begin
      status = 32'h0000_0000;
      status[0] = alarm_reg;
      status[1] = running_reg;
      status[2] = pulseBusy;
      status[3] = freeStatus;
      status[4] = homing_reg;
      status[5] = motionEnd;
      status[6] = lg.torqueLimit;
      status[`MIO_ST_PROG_MSB:`MIO_ST_PROG_LSB] = seqProgram;
      status[`MIO_ST_GIN_MSB:`MIO_ST_GIN_LSB]   = lg.generalIn;
   end
endmodule

// >>> mio_defs.svh
// Register map, field positions, reset values and timing for the motion I/O block
`ifndef MIO_DEFS_SVH
`define MIO_DEFS_SVH
`define MIO_ADDR_W        8
`define MIO_ADDR_CTRL     8'h00
`define MIO_ADDR_INPOL    8'h04
`define MIO_ADDR_OUTPOL   8'h08
`define MIO_ADDR_GOUT     8'h0c
`define MIO_ADDR_CMD      8'h10
`define MIO_ADDR_STATUS   8'h14
`define MIO_ADDR_POSERR   8'h18
`define MIO_ADDR_FAULT    8'h1c
`define MIO_CTRL_LAUNCH   0
`define MIO_CTRL_DFIN     1
`define MIO_CTRL_SLESS    2
`define MIO_CTRL_FREE     3
`define MIO_CTRL_CRIT_LSB 8
`define MIO_CTRL_CRIT_MSB 15
`define MIO_CMD_FRESET    0
`define MIO_CMD_ABORT     1
`define MIO_CMD_START     2
`define MIO_GOUT_ASN_LSB  4
`define MIO_GOUT_ASN_MSB  7
`define MIO_ST_PROG_LSB   8
`define MIO_ST_PROG_MSB   14
`define MIO_ST_GIN_LSB    16
`define MIO_ST_GIN_MSB    22
`define MIO_CTRL_RST      32'h0000_0000
`define MIO_POL_RST       32'h0000_0000
`define MIO_GOUT_RST      32'h0000_0000
`define MIO_CAUSE_DRIVER  8'h01
`define MIO_RESP_OK       2'b00
`define MIO_RESP_ERR      2'b10
`define MIO_CLK_HZ        10000000
`define MIO_BLINK_MS      200
`define MIO_BLINK_GAP     3'h4
`endif

// >>> mio_pkg.sv
// Types shared by the motion I/O block
package mio_pkg;
   // Logical input pins; bit order matches the input polarity register
   typedef struct packed {
      logic       faultReset;
      logic       start;
      logic       abort;
      logic       jogPos;
      logic       jogNeg;
      logic       homePos;
      logic       homeNeg;
      logic       free;
      logic       poserrClear;
      logic       torqueLimit;
      logic [6:0] generalIn;
   } mio_pins_t;

   // Output pins; bit order matches the output polarity register
   typedef struct packed {
      logic       alarm;
      logic       motionEnd;
      logic       running;
      logic       moving;
      logic       torqueLimit;
      logic       brakeFree;
      logic [3:0] generalOut;
   } mio_outs_t;

   typedef enum logic [2:0] {
      MIO_MV_NONE     = 3'b000,
      MIO_MV_JOG_POS  = 3'b001,
      MIO_MV_JOG_NEG  = 3'b010,
      MIO_MV_HOME_POS = 3'b011,
      MIO_MV_HOME_NEG = 3'b100
   } mio_motion_t;

   typedef enum logic [1:0] {
      MIO_BL_IDLE = 2'b00,
      MIO_BL_ON   = 2'b01,
      MIO_BL_OFF  = 2'b10,
      MIO_BL_GAP  = 2'b11
   } mio_blink_t;
endpackage

// >>> mio_signal_logic_monitor.sv
// Checker for the motion I/O pin rules
`timescale 1ns/1ps
module mio_signal_logic_monitor
   import mio_pkg::*;
(
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire mio_pins_t   pinsIn,
   input wire logic        remoteFreeIn,
   input wire logic        pulseBusy,
   input wire logic        protFaultIn,
   input wire logic        driverAlarmIn,
   input wire logic        seqStart,
   input wire logic        motionStop,
   input wire mio_motion_t motionReq,
   input wire mio_outs_t   pinsOut
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   alarm_set_a: assert property (protFaultIn |=> pinsOut.alarm)
      else $error("alarm not raised");
   fault_clear_a: assert property ($rose(pinsIn.faultReset) && !driverAlarmIn
      && !protFaultIn |-> ##[3:4] !pinsOut.alarm) else $error("alarm not cleared");
   abort_stop_a: assert property ($rose(pinsIn.abort) |-> ##3 motionStop)
      else $error("abort gave no stop");
   jog_start_a: assert property ($rose(pinsIn.jogPos) ##2 !pulseBusy
      |=> motionReq == MIO_MV_JOG_POS) else $error("jog request missing");
   busy_reject_a: assert property ($rose(pinsIn.jogNeg) ##2 pulseBusy
      |=> motionReq == MIO_MV_NONE) else $error("motion taken while moving");
   torque_follow_a: assert property (pinsOut.torqueLimit == $past(pinsIn.torqueLimit, 2))
      else $error("torque limit out of step");
   moving_out_a: assert property (pinsOut.moving == pulseBusy)
      else $error("moving output wrong");
   brake_free_a: assert property ($past(pinsIn.free, 2) || ($past(remoteFreeIn)
      && remoteFreeIn) |-> pinsOut.brakeFree) else $error("brake free missing");
   seq_launch_a: assert property ($rose(pinsIn.start) ##2 !pinsOut.running
      |=> seqStart && pinsOut.running) else $error("sequence not started");
endmodule

bind mio_signal_logic mio_signal_logic_monitor mon (.core_clk, .resetn, .pinsIn,
   .remoteFreeIn, .pulseBusy, .protFaultIn, .driverAlarmIn, .seqStart, .motionStop,
   .motionReq, .pinsOut);

// >>> mio_drive_model.sv
// Pulse generator stand-in answering motion requests
`timescale 1ns/1ps
module mio_drive_model
   import mio_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        resetn,
   input  wire mio_motion_t motionReq,
   input  wire logic        motionStop,
   output logic             pulseBusy
);
   int cnt;
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) cnt <= 0;
      else if (motionStop) cnt <= 0;
      else if (motionReq != MIO_MV_NONE) cnt <= 30;
      else if (cnt > 0) cnt <= cnt - 1;
   end
   assign pulseBusy = cnt > 0;
endmodule

// >>> test_motion_io_signal_logic.sv
// Self-checking bench for the motion I/O signal logic
`timescale 1ns/1ps
`include "mio_defs.svh"
module test_motion_io_signal_logic import mio_pkg::*;;
   logic        core_clk = 1'b0, resetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, remoteFreeIn, pulseBusy;
   logic        driverMoveIn, driverAlarmIn, protFaultIn, seqOutWe, seqResume;
   logic        motionStop, cmdPosLoad, seqDoneIn, driverEndIn;
   logic [1:0]  bresp, rresp;
   logic [3:0]  seqOutVal;
   logic [7:0]  awaddr, araddr, protCauseIn;
   logic [31:0] wdata, rdata, feedbackPosition, cmdPosValue, lastPos;
   mio_pins_t   pinsIn;
   mio_outs_t   pinsOut;
   mio_motion_t motionReq, lastReq;
   int          n_errors = 0, checks = 0, nResume = 0;
   always #50 core_clk = ~core_clk;
   mio_signal_logic #(.BLINK_CYC(4)) dut (.core_clk, .resetn, .awaddr, .awvalid, .awready,
      .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .pinsIn, .remoteFreeIn, .pulseBusy,
      .inEndArea(1'b0), .driverEndIn, .driverMoveIn, .driverAlarmIn, .protFaultIn,
      .protCauseIn, .seqLastMotionIn(1'b0), .seqDoneIn, .seqOutWe, .seqOutVal,
      .feedbackPosition, .commandedPosition(32'h0), .seqStart(), .seqResume, .seqAbort(),
      .seqProgram(), .motionReq, .motionStop, .cmdPosLoad, .cmdPosValue, .devClear(),
      .homePressSense(), .ledOn(), .pinsOut);
   mio_drive_model drv (.core_clk, .resetn, .motionReq, .motionStop, .pulseBusy);
   always @(posedge core_clk) begin
      if (motionReq != MIO_MV_NONE) lastReq <= motionReq;
      if (cmdPosLoad) lastPos <= cmdPosValue;
      if (seqResume) nResume <= nResume + 1;
   end
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tmo(input int t);
      if (t >= 200) begin
         n_errors++;
         wrap_up();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
      int t;
      t = 0;
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         t++;
      end while (!bvalid && t < 200);
      bready <= 1'b0;
      chk("bresp", bresp, r);
      tmo(t);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] m, e, input logic [1:0] r);
      int t;
      t = 0;
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge core_clk);
         if (arready) arvalid <= 1'b0;
         t++;
      end while (!rvalid && t < 200);
      rready <= 1'b0;
      chk("rdata", rdata & m, e);
      chk("rresp", rresp, r);
      tmo(t);
   endtask
   task automatic st(input logic [31:0] m, e);
      rd(`MIO_ADDR_STATUS, m, e, `MIO_RESP_OK);
   endtask
   // Six edges cover sync and edge register
   task automatic tog(input logic [16:0] m);
      @(posedge core_clk);
      pinsIn <= pinsIn ^ m;
      repeat (6) @(posedge core_clk);
   endtask
   initial begin
      {resetn, awvalid, wvalid, bready, arvalid, rready, seqDoneIn, seqOutWe, driverEndIn} = '0;
      {remoteFreeIn, driverMoveIn, driverAlarmIn, protFaultIn, awaddr, araddr, wdata} = '0;
      {pinsIn, protCauseIn, seqOutVal, feedbackPosition} = {17'h5, 8'h07, 4'ha, 32'h1234};
      repeat (2) @(posedge core_clk);
      resetn <= 1'b1;
      for (int i = 0; i < 4; i++) rd(8'(i * 4), '1, 32'h0, `MIO_RESP_OK);
      rd(8'h20, '1, 32'h0, `MIO_RESP_ERR);
      wr(8'h24, 32'h1, `MIO_RESP_ERR);
      $display("register test done");
      @(posedge core_clk) protFaultIn <= 1'b1;
      @(posedge core_clk) protFaultIn <= 1'b0;
      st(32'h1, 32'h1);
      rd(`MIO_ADDR_FAULT, 32'hff, 32'h07, `MIO_RESP_OK);
      tog(17'h10000);
      st(32'h1, 32'h0);
      tog(17'h10000);
      @(posedge core_clk) driverAlarmIn <= 1'b1;
      @(posedge core_clk) driverAlarmIn <= 1'b0;
      rd(`MIO_ADDR_FAULT, 32'hff, `MIO_CAUSE_DRIVER, `MIO_RESP_OK);
      wr(`MIO_ADDR_CMD, 32'h1, `MIO_RESP_OK);
      st(32'h1, 32'h0);
      $display("alarm test done");
      tog(17'h08000);
      st(32'h7f02, 32'h0502);
      tog(17'h08000);
      st(32'h2, 32'h2);
      tog(17'h08000);
      chk("resume", nResume, 1);
      tog(17'h08000);
      @(posedge core_clk) seqDoneIn <= 1'b1;
      @(posedge core_clk) seqDoneIn <= 1'b0;
      wr(`MIO_ADDR_CTRL, 32'h1, `MIO_RESP_OK);
      tog(17'h08000);
      st(32'h2, 32'h2);
      tog(17'h08000);
      st(32'h2, 32'h0);
      $display("sequence test done");
      tog(17'h02000);
      tog(17'h01000);
      chk("req", lastReq, MIO_MV_JOG_POS);
      st(32'h4, 32'h4);
      @(posedge core_clk) driverMoveIn <= 1'b1;
      tog(17'h04000);
      tog(17'h04000);
      st(32'h4, 32'h0);
      tog(17'h03000);
      for (int i = 0; i < 4; i++) begin
         tog(17'h02000 >> i);
         chk("req", lastReq, i + 1);
         tog(17'h04000);
         tog(17'h04000);
         tog(17'h02000 >> i);
      end
      $display("motion test done");
      tog(17'h00200);
      st(32'h8, 32'h8);
      tog(17'h00200);
      st(32'h8, 32'h0);
      chk("end", pinsOut.motionEnd, 1);
      wr(`MIO_ADDR_CTRL, 32'ha, `MIO_RESP_OK);
      chk("brake", pinsOut.brakeFree, 1);
      chk("end", pinsOut.motionEnd, 0);
      @(posedge core_clk) driverEndIn <= 1'b1;
      @(posedge core_clk) chk("end", pinsOut.motionEnd, 1);
      tog(17'h00180);
      chk("torque", pinsOut.torqueLimit, 1);
      chk("pos", lastPos, 32'h1234);
      tog(17'h00180);
      $display("pin test done");
      wr(`MIO_ADDR_GOUT, 32'h5, `MIO_RESP_OK);
      chk("gout", pinsOut.generalOut, 4'h5);
      wr(`MIO_ADDR_OUTPOL, 32'h1, `MIO_RESP_OK);
      chk("gout", pinsOut.generalOut, 4'h4);
      @(posedge core_clk) seqOutWe <= 1'b1;
      @(posedge core_clk) seqOutWe <= 1'b0;
      rd(`MIO_ADDR_GOUT, 32'hf, 32'ha, `MIO_RESP_OK);
      $display("output test done");
      wrap_up();
   end
endmodule
